/* logic/isp_tap_programmer.sv */
/*
  Test access port with in-system programming of a flip-flop configuration
  array: bypass, identification, enable, erase, program and verify.
  Assumes the test pins come from outside and are sampled by mclk_i, which
  runs far faster than the test clock; sys_rst_i is the power-up reset.
*/
`timescale 1ns/1ps

// Contract
// [R1] Reprogram array in-system with internal pump
// [R2] Code 1001 arms erase, program, verify
// [R3] Controller arms before first programming instruction
// [R4] Code 1010 erases whole array
// [R5] Code 1011 writes shift register row
// [R6] Code 1100 loads addressed row into register
// [R7] Controller shifts out and compares verify data
// [R8] Outputs take user verify states during verify
// [R9] Test clock at most 10 MHz; the bench controller model runs it at 31.25 MHz (32 ns period)
// [R10] Controller waits 100 ms after erase
// [R11] Controller holds program 10 ms
// [R12] Controller waits 10 us before verify shift
// [R13] Controller waits 100 us before programming
// [R14] Sample on rising, drive output on falling
// [R15] Four-bit instruction; 1111 selects bypass bit
// [R16] Controller keeps mode-select high in user mode
// [R17] Power-up reset resets test logic
// [R18] Controller times operations in idle state
// [R19] Row address travels in the shift register
module isp_tap_programmer
  import isp_pkg::*;
(
  input wire logic mclk_i, // Block clock, 250 MHz.
  input wire logic sys_rst_i, // Power-up reset, active high.
  input wire logic tck_i, // Test clock pin.
  input wire logic tms_i, // Mode-select pin.
  input wire logic tdi_i, // Serial data in pin.
  output logic tdo_o, // Serial data out.
  output logic tdo_oe_o, // High while tdo_o is driven.
  input wire logic [`GP_W-1:0] user_out_i, // Outputs of normal operation.
  input wire logic [`GP_W-1:0] verify_out_i, // Outputs chosen for verify.
  output logic [`GP_W-1:0] gp_o, // General-purpose outputs.
  output logic pump_on_o // Charge pump running.
);
  tap_pins_t pins_s1, pins_s2;
  logic tck_d, tck_rise, tck_fall;

  tap_state_t state, next_state;
  logic [`IR_W-1:0] ir, next_ir, ir_sr, next_ir_sr;
  logic [`SR_W-1:0] isp_sr, next_isp_sr;
  logic [31:0] id_sr, next_id_sr;
  logic byp, next_byp, armed, next_armed, next_tdo, next_tdo_oe;
  logic upd_ir, upd_dr, go, isp_sel;
  logic [`IR_W-1:0] cmd;

  logic pend_prog, next_pend_prog, pend_erase, next_pend_erase;
  logic pend_verify, next_pend_verify, next_pump_on;
  logic [`CNT_W-1:0] wr_cnt, next_wr_cnt;
  logic [`GP_W-1:0] next_gp;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready, wr_idle, erase_do, verify_do;
  row_word_t fifo_out, isp_word;
  logic [`ROW_W-1:0] rows [`ROWS];

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pins_s1 <= '0;
      pins_s2 <= '0;
      tck_d <= 1'b0;
    end
    else
    begin
      pins_s1 <= {tck_i, tms_i, tdi_i};
      pins_s2 <= pins_s1;
      tck_d <= pins_s2.tck;
    end
  end

  assign tck_rise = pins_s2.tck && !tck_d; // R14
  assign tck_fall = !pins_s2.tck && tck_d; // R14
  assign upd_ir = tck_rise && (state == ST_UPD_IR);
  assign upd_dr = tck_rise && (state == ST_UPD_DR);
  assign cmd = upd_ir ? ir_sr : ir;
  assign go = (upd_ir || upd_dr) && armed;
  assign isp_sel = (ir == `IR_ENABLE) || (ir == `IR_ERASE) || (ir == `IR_PROGRAM) ||
    (ir == `IR_VERIFY);
  assign isp_word = row_word_t'(isp_sr); // R19

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RESET: next_state = pins_s2.tms ? ST_RESET : ST_IDLE;
      ST_IDLE: next_state = pins_s2.tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = pins_s2.tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = pins_s2.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = pins_s2.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = pins_s2.tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = pins_s2.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = pins_s2.tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: next_state = pins_s2.tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = pins_s2.tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: next_state = pins_s2.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = pins_s2.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = pins_s2.tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = pins_s2.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = pins_s2.tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: next_state = pins_s2.tms ? ST_SEL_DR : ST_IDLE;
      default: next_state = ST_RESET;
    endcase
    if (!tck_rise)
    begin
      next_state = state;
    end
  end

  // Shift registers move on the rising test-clock edge, LSB out first.
  always_comb
  begin
    next_ir = ir;
    next_ir_sr = ir_sr;
    next_isp_sr = isp_sr;
    next_id_sr = id_sr;
    next_byp = byp;
    next_armed = armed;
    next_tdo = tdo_o;
    next_tdo_oe = tdo_oe_o;
    if (tck_rise)
    begin
      case (state)
        ST_RESET:
        begin
          next_ir = `IR_RESET;
          next_armed = 1'b0;
        end
        ST_CAP_IR: next_ir_sr = `IR_CAPTURE;
        ST_SHIFT_IR: next_ir_sr = {pins_s2.tdi, ir_sr[`IR_W-1:1]};
        ST_UPD_IR:
        begin
          next_ir = ir_sr; // R15
          next_armed = (ir_sr == `IR_ENABLE) || (armed && (ir_sr == `IR_ERASE || // R2
            ir_sr == `IR_PROGRAM || ir_sr == `IR_VERIFY));
        end
        ST_CAP_DR:
        begin
          next_byp = 1'b0;
          next_id_sr = `IDCODE_VAL;
        end
        ST_SHIFT_DR:
        begin
          next_byp = pins_s2.tdi; // R15
          next_id_sr = {pins_s2.tdi, id_sr[31:1]};
          if (isp_sel)
          begin
            next_isp_sr = {pins_s2.tdi, isp_sr[`SR_W-1:1]};
          end
        end
        default: next_ir = ir;
      endcase
    end
    if (verify_do)
    begin
      next_isp_sr = {isp_word.addr, rows[isp_word.addr]}; // R6
    end
    if (tck_fall)
    begin
      next_tdo_oe = (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR); // R14
      if (state == ST_SHIFT_IR)
      begin
        next_tdo = ir_sr[0];
      end
      else if (isp_sel)
      begin
        next_tdo = isp_sr[0];
      end
      else if (ir == `IR_IDCODE)
      begin
        next_tdo = id_sr[0];
      end
      else
      begin
        next_tdo = byp; // R15
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state <= ST_RESET; // R17
      ir <= `IR_RESET;
      ir_sr <= `IR_CAPTURE;
      isp_sr <= '0;
      id_sr <= '0;
      byp <= 1'b0;
      armed <= 1'b0;
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ir <= next_ir;
      ir_sr <= next_ir_sr;
      isp_sr <= next_isp_sr;
      id_sr <= next_id_sr;
      byp <= next_byp;
      armed <= next_armed;
      tdo_o <= next_tdo;
      tdo_oe_o <= next_tdo_oe;
    end
  end

  // Rows queue in the FIFO; each write holds the pump for a settle time.
  assign wr_idle = !fifo_out_valid && (wr_cnt == '0);
  assign erase_do = pend_erase && wr_idle; // R4
  assign verify_do = pend_verify && wr_idle && !pend_erase && !pend_prog;
  assign fifo_out_ready = (wr_cnt == `CNT_W'(1));

  always_comb
  begin
    next_pend_prog = (pend_prog && !fifo_in_ready) || (go && cmd == `IR_PROGRAM); // R5
    next_pend_erase = (pend_erase && !erase_do) || (go && cmd == `IR_ERASE); // R4
    next_pend_verify = (pend_verify && !verify_do) || (go && cmd == `IR_VERIFY); // R6
    next_wr_cnt = wr_cnt;
    if (wr_cnt != '0)
    begin
      next_wr_cnt = wr_cnt - 1'b1;
    end
    else if (fifo_out_valid)
    begin
      next_wr_cnt = `PUMP_SETTLE;
    end
    next_pump_on = (next_wr_cnt != '0) || erase_do; // R1
    next_gp = (armed && ir == `IR_VERIFY) ? verify_out_i : user_out_i; // R8
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pend_prog <= 1'b0;
      pend_erase <= 1'b0;
      pend_verify <= 1'b0;
      wr_cnt <= '0;
      pump_on_o <= 1'b0;
      gp_o <= '0;
    end
    else
    begin
      pend_prog <= next_pend_prog;
      pend_erase <= next_pend_erase;
      pend_verify <= next_pend_verify;
      wr_cnt <= next_wr_cnt;
      pump_on_o <= next_pump_on;
      gp_o <= next_gp;
    end
  end

  isp_row_fifo u_fifo (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(pend_prog),
    .in_ready_o(fifo_in_ready),
    .in_data_i(isp_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out)
  );

  for (genvar i = 0; i < `ROWS; i++)
  begin : g_row
    logic [`ROW_W-1:0] next_row;
    always_comb
    begin
      next_row = rows[i];
      if (erase_do)
      begin
        next_row = `ERASED_ROW; // R4
      end
      else if (fifo_out_valid && fifo_out_ready && fifo_out.addr == `ADDR_W'(i))
      begin
        next_row = fifo_out.data; // R5
      end
    end
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
      if (sys_rst_i)
      begin
        rows[i] <= `ERASED_ROW;
      end
      else
      begin
        rows[i] <= next_row;
      end
    end
  end
endmodule // isp_tap_programmer

/* logic/isp_cfg.svh */
/*
  Constants of the in-system programming block: instruction codes, array
  geometry, reset values and timing figures.
  Assumes it is included by the package and the modules, once per unit.
*/
`ifndef ISP_CFG_SVH
`define ISP_CFG_SVH

`define IR_W 4
`define IR_BYPASS 4'hF
`define IR_IDCODE 4'h1
`define IR_ENABLE 4'h9
`define IR_ERASE 4'hA
`define IR_PROGRAM 4'hB
`define IR_VERIFY 4'hC
`define IR_CAPTURE 4'h1
`define IR_RESET 4'h1

`define ROW_W 16
`define ADDR_W 3
`define ROWS 8
`define SR_W 19
`define GP_W 32
`define ERASED_ROW 16'h0000
// Identification value is arbitrary.
`define IDCODE_VAL 32'h1000_0001

`define CNT_W 4
`define PUMP_SETTLE 4'h8
`define FIFO_DEPTH 8

`define CLK_MHZ 250
`define TCK_MAX_MHZ 10
`define ERASE_PULSE_MIN_MS 100
`define PROGRAM_PULSE_MIN_MS 10
`define VERIFY_PULSE_MIN_US 10
`define INIT_MIN_US 100

`endif

/* logic/isp_pkg.sv */
/*
  Types shared by the programming block and its row FIFO.
  Assumes isp_cfg.svh is on the include path.
*/
`include "isp_cfg.svh"

package isp_pkg;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`ROW_W-1:0] data;
  } row_word_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_t;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_t;

endpackage

/* logic/isp_row_fifo.sv */
/*
  Flip-flop FIFO with valid and ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps

module isp_row_fifo
  import isp_pkg::*;
#(
  parameter int WIDTH = $bits(row_word_t),
  parameter int DEPTH = `FIFO_DEPTH
)
(
  input wire logic mclk_i, // Block clock.
  input wire logic sys_rst_i, // Asynchronous reset, active high.
  input wire logic in_valid_i, // Write request.
  output logic in_ready_o, // Room for a word.
  input wire logic [WIDTH-1:0] in_data_i, // Word to store.
  output logic out_valid_o, // A word is waiting.
  input wire logic out_ready_i, // Drain accepts the word.
  output logic [WIDTH-1:0] out_data_o // Oldest word.
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb
  begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule // isp_row_fifo

/* tb/isp_tap_programmer_chk.sv */
/* Port assertions for isp_tap_programmer.
   Assumes the bind at the foot attaches it to the block. */
`timescale 1ns/1ps
`include "isp_cfg.svh"
module isp_tap_programmer_chk
  import isp_pkg::*;
(
  input wire logic mclk_i, // Clock.
  input wire logic sys_rst_i, // Reset.
  input wire logic tck_i, // Test clock.
  input wire logic tms_i, // Mode select.
  input wire logic tdi_i, // Serial in.
  input wire logic tdo_o, // Serial out.
  input wire logic tdo_oe_o, // Out enable.
  input wire logic [`GP_W-1:0] user_out_i, // User values.
  input wire logic [`GP_W-1:0] verify_out_i, // Verify values.
  input wire logic [`GP_W-1:0] gp_o, // Outputs.
  input wire logic pump_on_o // Pump.
);
  logic [6:0] pump_run;
  logic [6:0] next_pump_run;
  always_comb next_pump_run = pump_on_o ? pump_run + 7'h1 : 7'h0;
  always_ff @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i)
      pump_run <= 7'h0;
    else
      pump_run <= next_pump_run;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  sequence tck_high_s; tck_i [*4]; endsequence
  sequence tdo_move_s; $changed(tdo_o); endsequence
  rst_quiet_a: assert property (disable iff (1'b0) sys_rst_i [*2] |->
    !tdo_oe_o && !tdo_o && !pump_on_o && gp_o == '0) else $error("output active in reset");
  tdo_fall_a: assert property (tdo_move_s |-> !$past(tck_i, 2))
    else $error("tdo moved off the low phase");
  tdo_hold_a: assert property (tck_high_s |-> $stable(tdo_o) && $stable(tdo_oe_o))
    else $error("tdo moved in the high phase");
  tdo_min_a: assert property (tdo_move_s |=> $stable(tdo_o) [*7])
    else $error("tdo bit too short");
  oe_fall_a: assert property ($changed(tdo_oe_o) |-> !$past(tck_i))
    else $error("enable moved off the low phase");
  oe_min_a: assert property ($rose(tdo_oe_o) |=> tdo_oe_o [*8])
    else $error("enable too short");
  gp_pick_a: assert property (!$past(sys_rst_i) |->
    gp_o == $past(user_out_i) || gp_o == $past(verify_out_i)) else $error("bad gp value");
  pump_len_a: assert property (pump_run <= 7'h48) else $error("pump on too long");
endmodule // isp_tap_programmer_chk

bind isp_tap_programmer isp_tap_programmer_chk i_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
  .user_out_i(user_out_i), .verify_out_i(verify_out_i), .gp_o(gp_o), .pump_on_o(pump_on_o));

/* tb/isp_ctl_model.sv */
/* Programming controller driving the test port.
   Assumes tdo_i already shows the pull-up level when the pin floats. */
`timescale 1ns/1ps
module isp_ctl_model
#(
  // Time is scaled down in the bench: the test clock runs with a 32 ns period.
  parameter int half_ns = 16,
  parameter int init_wait = 8,
  parameter int erase_pulse_min = 4,
  parameter int program_pulse_min = 4,
  parameter int verify_pulse_min = 2
)
(
  output logic tck_o, // Test clock.
  output logic tms_o, // Mode select.
  output logic tdi_o, // Serial data out.
  input wire logic tdo_i // Serial data in.
);
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  task automatic clk_bit(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #(half_ns);
    q = tdo_i;
    tck_o = 1'b1;
    #(half_ns);
    tck_o = 1'b0;
  endtask
  task automatic idle(input int n);
    logic q;
    repeat (n) clk_bit(1'b0, 1'b0, q);
  endtask
  task automatic start();
    #(2 * half_ns * init_wait);
    idle(1);
  endtask
  // Walks from idle through one scan and back to idle, LSB first.
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    clk_bit(1'b1, 1'b0, q);
    if (ir)
      clk_bit(1'b1, 1'b0, q);
    clk_bit(1'b0, 1'b0, q);
    clk_bit(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      clk_bit(i == n - 1, din[i], q);
      dout[i] = q;
    end
    clk_bit(1'b1, 1'b0, q);
    clk_bit(1'b0, 1'b0, q);
  endtask
  task automatic cmd(input logic [3:0] code, input int n);
    logic [31:0] d;
    scan(1'b1, 4, {28'h000_0000, code}, d);
    idle(n);
  endtask
endmodule // isp_ctl_model

/* tb/isp_tap_programmer_tb.sv */
/* Self-checking bench for the programming block and its row FIFO.
   Assumes the controller model and the bound checker are compiled. */
`timescale 1ns/1ps
`include "isp_cfg.svh"
module isp_tap_programmer_tb;
  import isp_pkg::*;
  localparam logic [31:0] usr_val = 32'h5A5A_0F0F;
  localparam logic [31:0] vfy_val = 32'hC3C3_1234;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, tdo_w, pump;
  logic [`GP_W-1:0] user_out = usr_val;
  logic [`GP_W-1:0] verify_out = vfy_val;
  logic [`GP_W-1:0] gp;
  logic [31:0] d;
  int n_checks = 0;
  int n_mismatch = 0;
  int n_pump = 0;
  int p0;
  assign tdo_w = tdo_oe ? tdo : 1'b1;
  isp_tap_programmer i_dut (.mclk_i(mclk), .sys_rst_i(rst), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .user_out_i(user_out),
    .verify_out_i(verify_out), .gp_o(gp), .pump_on_o(pump));
  isp_ctl_model i_ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_w));
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  always @(posedge pump) n_pump++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask
  function automatic logic [31:0] row(input int a, input logic [15:0] v);
    return {13'h0000, 3'(a), v};
  endfunction
  function automatic logic [15:0] pat(input int r);
    return 16'h1357 ^ 16'(r * 16'h1111);
  endfunction
  // Two writes to one row pass the queue in order; the later one must win.
  task automatic t_fifo();
    p0 = n_pump;
    i_ctl.cmd(`IR_ENABLE, 0);
    i_ctl.scan(1'b0, `SR_W, row(5, 16'h1111), d);
    i_ctl.cmd(`IR_PROGRAM, i_ctl.program_pulse_min);
    i_ctl.scan(1'b0, `SR_W, row(5, 16'h2222), d);
    chk(d, row(5, 16'h1111), "shift register kept");
    i_ctl.idle(i_ctl.program_pulse_min);
    chk(n_pump - p0, 32'd2, "queued rows");
    chk({31'h0, pump}, 32'h0, "pump idle");
    i_ctl.cmd(`IR_VERIFY, i_ctl.verify_pulse_min);
    i_ctl.scan(1'b0, `SR_W, 32'h0, d);
    chk(d, row(5, 16'h2222), "queue order");
  endtask
  task automatic t_idcode();
    i_ctl.scan(1'b0, 32, 32'h0, d);
    chk(d, `IDCODE_VAL, "idcode");
    i_ctl.scan(1'b1, 4, {28'h0, `IR_BYPASS}, d);
    chk({28'h0, d[3:0]}, 32'h1, "ir capture");
    i_ctl.scan(1'b0, 8, 32'hA5, d);
    chk({24'h0, d[7:0]}, 32'h4A, "bypass");
    chk({31'h0, tdo_oe}, 32'h0, "tdo released");
  endtask
  task automatic t_refused();
    i_ctl.cmd(`IR_PROGRAM, 1);
    i_ctl.scan(1'b0, `SR_W, row(3, 16'hBEEF), d);
    i_ctl.cmd(`IR_VERIFY, 2);
    chk(gp, usr_val, "unarmed gp");
    i_ctl.cmd(`IR_ENABLE, 1);
    i_ctl.cmd(`IR_VERIFY, 2);
    chk(gp, vfy_val, "verify gp");
    i_ctl.scan(1'b0, `SR_W, 32'h0, d);
    chk(d, row(3, `ERASED_ROW), "refused program");
  endtask
  task automatic t_prog();
    p0 = n_pump;
    i_ctl.cmd(`IR_ENABLE, 1);
    i_ctl.cmd(`IR_PROGRAM, 1);
    for (int r = 0; r < `ROWS; r++)
    begin
      i_ctl.scan(1'b0, `SR_W, row(r, pat(r)), d);
      i_ctl.idle(i_ctl.program_pulse_min);
    end
    chk(n_pump - p0, 32'd9, "pump pulses");
    i_ctl.cmd(`IR_VERIFY, 1);
    i_ctl.scan(1'b0, `SR_W, row(0, 16'h0), d);
    for (int r = 0; r < `ROWS; r++)
    begin
      i_ctl.cmd(`IR_VERIFY, i_ctl.verify_pulse_min);
      i_ctl.scan(1'b0, `SR_W, row(r + 1, 16'h0), d);
      chk(d, row(r, pat(r)), "verify row");
    end
  endtask
  task automatic t_erase();
    p0 = n_pump;
    i_ctl.cmd(`IR_ERASE, i_ctl.erase_pulse_min);
    chk(gp, usr_val, "erase gp");
    chk(n_pump - p0, 32'd1, "erase pump");
    i_ctl.cmd(`IR_VERIFY, i_ctl.verify_pulse_min);
    i_ctl.scan(1'b0, `SR_W, 32'h0, d);
    chk(d, row(0, `ERASED_ROW), "erased row");
  endtask
  task automatic t_reset();
    @(negedge mclk);
    rst = 1'b1;
    user_out = ~usr_val;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    i_ctl.start();
    chk(gp, ~usr_val, "gp follows user");
    i_ctl.scan(1'b0, 32, 32'h0, d);
    chk(d, `IDCODE_VAL, "idcode after reset");
    i_ctl.cmd(`IR_VERIFY, 2);
    chk(gp, ~usr_val, "arming cleared");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    i_ctl.start();
    t_idcode();
    t_refused();
    t_prog();
    t_fifo();
    t_erase();
    t_reset();
    end_of_test();
  end
  initial
  begin
    #300000;
    n_mismatch++;
    end_of_test();
  end
endmodule // isp_tap_programmer_tb
